// ---- codec_serial_pkg.sv ----
// Purpose: constants and types for the codec serial port block
// Assumes: register index equals the word address on the bus
// Notes:   byte address of a register is four times its index
package codec_serial_pkg;

  // ==========================================
  // register indices
  localparam logic [3:0] OFS_DIR      = 4'h8;
  localparam logic [3:0] OFS_FMT      = 4'h9;
  localparam logic [3:0] OFS_OFFSET   = 4'ha;
  localparam logic [3:0] OFS_OVF      = 4'hb;
  localparam logic [3:0] OFS_IRQ_ST   = 4'hc;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hd;

  // ==========================================
  // field positions and reset values
  localparam int DIR_BCLK_BIT = 7;
  localparam int DIR_WCLK_BIT = 6;
  localparam int DIR_TRI_BIT  = 5;
  localparam int OVF_LSB      = 4;
  localparam logic [7:0] DIR_RST    = 8'h00;
  localparam logic [7:0] FMT_RST    = 8'h00;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [7:0] OVF_RST    = 8'h01;
  localparam logic [4:0] PLL_R_ZERO = 5'h10;

  // ==========================================
  // frame timing
  localparam logic [8:0] FRAME_256 = 9'h100;
  localparam logic [5:0] WL_BITS [4] = '{6'h10, 6'h14, 6'h18, 6'h20};

  typedef enum logic [1:0] {
    FMT_I2S = 2'h0,
    FMT_DSP = 2'h1,
    FMT_RJ  = 2'h2,
    FMT_LJ  = 2'h3
  } xfer_fmt_t;

  typedef struct packed {
    xfer_fmt_t  mode;
    logic [1:0] wl;
    logic       rate256;
    logic [1:0] rs_en;
    logic       mute_sel;
  } ser_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic       ch;
    logic [4:0] idx;
  } win_t;

  typedef enum logic [2:0] {RS_IDLE, RS_DOWN, RS_ALIGN, RS_UP, RS_HOLD} rs_state_t;

endpackage : codec_serial_pkg

// ---- codec_serial_port.sv ----
// Purpose: serial format control, re-sync and overflow flags of a codec port
// Assumes: converter events and delay figures arrive on core_clk
// Notes:   link clocks are sampled by core_clk; bit clock well below 50 MHz
// Functional notes
// - two-bit mode field picks i2s, dsp, right or left justified framing
// - word length field gives 16, 20, 24 or 32 bit samples
// - rate select matters only as bit clock master; clear means continuous
// - rate select set as master gives 256 bit clocks per frame
// - playback converter realigns when delay drifts over a quarter period
// - record converter realigns when delay drifts over a quarter period
// - mute select makes each realignment happen under soft mute
// - offset places data 0 to 255 bit clocks after frame start
// - dsp framing counts the offset from the word clock rising edge
// - four sticky overflow flags for both adc and dac channels
// - reading the overflow register returns then clears the flags
// - pll r code gives its value, code zero gives sixteen
// - direction bits make bit and word clock pins inputs or outputs
// - tri-state option releases data output outside valid data bits
`timescale 1ns/1ps
module codec_serial_port
  import codec_serial_pkg::*;
#(
  parameter int BCLK_HALF   = 4,
  parameter int MUTE_CYCLES = 64
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // avalon-mm slave, word addressed
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  // serial pins
  input  wire logic              bclk_i,
  output logic                   bclk_o,
  output logic                   bclk_oe,
  input  wire logic              wclk_i,
  output logic                   wclk_o,
  output logic                   wclk_oe,
  input  wire logic              din_i,
  output logic                   dout_o,
  output logic                   dout_oe,
  // sample words, data right aligned
  input  wire logic [31:0]       tx_left,
  input  wire logic [31:0]       tx_right,
  output logic      [31:0]       rx_left,
  output logic      [31:0]       rx_right,
  output logic                   rx_valid,
  // converters: index 1 playback, index 0 record
  input  wire logic [3:0]        ovf_evt,
  input  wire logic [1:0][15:0]  delay_err,
  input  wire logic [1:0][15:0]  period,
  output logic      [1:0]        resync_pulse,
  output logic      [1:0]        soft_mute,
  output logic      [4:0]        pll_r_divide
);

  if (BCLK_HALF < 1 || BCLK_HALF > 65535) begin : g_bad_half
    $error("BCLK_HALF out of range");
  end
  // the realign check below waits MUTE_CYCLES + 2 cycles and must stay under 1000
  if (MUTE_CYCLES < 1 || MUTE_CYCLES > 997) begin : g_bad_mute
    $error("MUTE_CYCLES out of range");
  end
  localparam int RS_BOUND = MUTE_CYCLES + 2;

  // ==========================================
  // reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic       srst_b;
  logic [2:0] pin1_q, pin2_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rst_sync_q <= 2'h0;
    else        rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign srst_b = rst_sync_q[1];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin1_q <= 3'h0;
      pin2_q <= 3'h0;
    end else begin
      pin1_q <= {bclk_i, wclk_i, din_i};
      pin2_q <= pin1_q;
    end
  end

  // ==========================================
  // register file and bus slave
  ser_cfg_t   fmt_q, fmt_d;
  logic [7:0] dir_q, dir_d, ofs_q, ofs_d;
  logic [3:0] ovf_q, ovf_d, pllr_q, pllr_d;
  logic [5:0] ist_q, ist_d, imask_q, imask_d;
  logic       wait_q, wait_d, irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic [4:0] pdiv_q, pdiv_d;
  logic       acc_wr, acc_rd;

  always_comb begin
    fmt_d   = fmt_q;
    dir_d   = dir_q;
    ofs_d   = ofs_q;
    pllr_d  = pllr_q;
    imask_d = imask_q;
    rdata_d = rdata_q;
    // answer one cycle after the request; accepted while wait is low
    wait_d  = !((avs_read || avs_write) && wait_q);
    acc_wr  = avs_write && !wait_q && avs_byteenable[0];
    acc_rd  = avs_read && !wait_q;
    ist_d   = ist_q | {resync_pulse, ovf_evt};
    ovf_d   = ovf_q;
    if (acc_rd && avs_address == OFS_OVF)
      ovf_d = ovf_q & ~rdata_q[OVF_LSB +: 4];
    ovf_d = ovf_d | ovf_evt;
    if (avs_read && wait_q) begin
      case (avs_address)
        OFS_DIR:      rdata_d = {24'h0, dir_q};
        OFS_FMT:      rdata_d = {24'h0, fmt_q};
        OFS_OFFSET:   rdata_d = {24'h0, ofs_q};
        OFS_OVF:      rdata_d = {24'h0, ovf_q, pllr_q};
        OFS_IRQ_ST:   rdata_d = {26'h0, ist_q};
        OFS_IRQ_MASK: rdata_d = {26'h0, imask_q};
        default:      rdata_d = 32'h0;
      endcase
    end
    if (acc_wr) begin
      case (avs_address)
        OFS_DIR:      dir_d   = avs_writedata[7:0];
        OFS_FMT:      fmt_d   = ser_cfg_t'(avs_writedata[7:0]);
        OFS_OFFSET:   ofs_d   = avs_writedata[7:0];
        OFS_OVF:      pllr_d  = avs_writedata[3:0];
        OFS_IRQ_ST:   ist_d   = (ist_q & ~avs_writedata[5:0]) | {resync_pulse, ovf_evt};
        OFS_IRQ_MASK: imask_d = avs_writedata[5:0];
        default:      ;
      endcase
    end
    pdiv_d = (pllr_q == 4'h0) ? PLL_R_ZERO : {1'b0, pllr_q};
    irq_d  = |(ist_q & imask_q);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_q   <= ser_cfg_t'(FMT_RST);
      dir_q   <= DIR_RST;
      ofs_q   <= OFFSET_RST;
      ovf_q   <= OVF_RST[7:4];
      pllr_q  <= OVF_RST[3:0];
      ist_q   <= 6'h0;
      imask_q <= 6'h0;
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
      pdiv_q  <= 5'h1;
      irq_q   <= 1'b0;
    end else if (!srst_b) begin
      wait_q  <= 1'b1;
    end else begin
      fmt_q   <= fmt_d;
      dir_q   <= dir_d;
      ofs_q   <= ofs_d;
      ovf_q   <= ovf_d;
      pllr_q  <= pllr_d;
      ist_q   <= ist_d;
      imask_q <= imask_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      pdiv_q  <= pdiv_d;
      irq_q   <= irq_d;
    end
  end

  // ==========================================
  // master clock generation
  logic [15:0] div_q, div_d;
  logic [8:0]  mbit_q, mbit_d, half_m, flen;
  logic        bclk_q, bclk_d, wclk_q, wclk_d, mtick;

  always_comb begin
    half_m = fmt_q.rate256 ? (FRAME_256 >> 1) : {3'h0, WL_BITS[fmt_q.wl]};
    flen   = {half_m[7:0], 1'b0};
    mtick  = dir_q[DIR_BCLK_BIT] && div_q == 16'(BCLK_HALF - 1);
    div_d  = 16'h0;
    mbit_d = mbit_q;
    bclk_d = 1'b0;
    wclk_d = wclk_q;
    if (dir_q[DIR_BCLK_BIT]) begin
      div_d  = mtick ? 16'h0 : div_q + 16'h1;
      bclk_d = mtick ? !bclk_q : bclk_q;
      if (mtick && bclk_q) begin
        mbit_d = (mbit_q >= flen - 9'h1) ? 9'h0 : mbit_q + 9'h1;
        case (fmt_q.mode)
          FMT_I2S: wclk_d = mbit_d >= half_m;
          FMT_DSP: wclk_d = mbit_d == 9'h0;
          default: wclk_d = mbit_d < half_m;
        endcase
      end
    end else begin
      mbit_d = 9'h0;
      wclk_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q  <= 16'h0;
      mbit_q <= 9'h0;
      bclk_q <= 1'b0;
      wclk_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      mbit_q <= mbit_d;
      bclk_q <= bclk_d;
      wclk_q <= wclk_d;
    end
  end

  // ==========================================
  // serial data engine on the link clocks
  logic        bl, wl_lv, bprev_q, wprev_q, chan_q, chan_d, rxv_q, rxv_d;
  logic        dout_q, dout_d, doe_q, doe_d, wedge, fst, hst, dval_q, dval_d;
  logic [8:0]  hbit_q, hbit_d, half_q, half_d, npos;
  logic [31:0] sh_q, sh_d, rxl_q, rxl_d, rxr_q, rxr_d, txl_q, txl_d, txr_q, txr_d, word;
  logic [31:0] wmask;
  win_t        w;

  function automatic win_t win(input logic [8:0] pos, input logic ch);
    logic [8:0] st, k, wlen;
    wlen = {3'h0, WL_BITS[fmt_q.wl]};
    case (fmt_q.mode)
      FMT_I2S: st = {1'b0, ofs_q} + 9'h1;
      FMT_RJ:  st = half_q - wlen + {1'b0, ofs_q};
      default: st = {1'b0, ofs_q};
    endcase
    k = pos - st;
    win.ch = ch;
    if (fmt_q.mode == FMT_DSP) begin
      win.valid = pos >= st && k < {wlen[7:0], 1'b0};
      win.ch    = k >= wlen;
      if (win.ch) k = k - wlen;
    end else begin
      win.valid = pos >= st && k < wlen;
    end
    win.last = k == wlen - 9'h1;
    win.idx  = 5'(wlen - 9'h1 - k);
  endfunction : win

  always_comb begin
    bl     = dir_q[DIR_BCLK_BIT] ? bclk_q : pin2_q[2];
    wl_lv  = dir_q[DIR_WCLK_BIT] ? wclk_q : pin2_q[1];
    wedge  = wl_lv ^ wprev_q;
    fst    = wedge && (fmt_q.mode == FMT_I2S ? !wl_lv : wl_lv);
    hst    = fst || (wedge && fmt_q.mode != FMT_DSP);
    hbit_d = hbit_q;
    chan_d = chan_q;
    half_d = half_q;
    sh_d   = sh_q;
    rxl_d  = rxl_q;
    rxr_d  = rxr_q;
    rxv_d  = 1'b0;
    txl_d  = txl_q;
    txr_d  = txr_q;
    dout_d = dout_q;
    dval_d = dval_q;
    // received words keep only the programmed word length, right aligned
    wmask  = 32'hffff_ffff >> (6'h20 - WL_BITS[fmt_q.wl]);
    npos   = hst ? 9'h0 : hbit_q + 9'h1;
    w      = win(9'h0, 1'b0);
    word   = 32'h0;
    if (bl && !bprev_q) begin
      // rising edge: advance the position and sample input data
      if (hst) begin
        hbit_d = 9'h0;
        chan_d = !fst;
        half_d = hbit_q + 9'h1;
      end else if (hbit_q != 9'h1ff) begin
        hbit_d = hbit_q + 9'h1;
      end
      // a link clock that stands still between frames gives no falling edge before bit 0
      if (fst) begin
        txl_d = tx_left;
        txr_d = tx_right;
      end
      w = win(hbit_d, chan_d);
      if (w.valid) begin
        sh_d = {sh_q[30:0], pin2_q[0]};
        if (w.last && w.ch) begin
          rxr_d = sh_d & wmask;
          rxv_d = 1'b1;
        end else if (w.last) begin
          rxl_d = sh_d & wmask;
        end
      end
    end else if (!bl && bprev_q) begin
      // falling edge: present the bit for the coming rising edge
      w = win(npos, hst ? !fst : chan_q);
      if (fst) begin
        txl_d = tx_left;
        txr_d = tx_right;
      end
      word   = w.ch ? (fst ? tx_right : txr_q) : (fst ? tx_left : txl_q);
      dout_d = w.valid && word[w.idx];
      dval_d = w.valid;
    end
    // released outside valid bits, also while the link clock stands still
    doe_d  = !dir_q[DIR_TRI_BIT] || dval_d;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bprev_q <= 1'b0;
      wprev_q <= 1'b0;
      hbit_q  <= 9'h1ff;
      chan_q  <= 1'b0;
      half_q  <= 9'h0;
      sh_q    <= 32'h0;
      rxl_q   <= 32'h0;
      rxr_q   <= 32'h0;
      rxv_q   <= 1'b0;
      txl_q   <= 32'h0;
      txr_q   <= 32'h0;
      dout_q  <= 1'b0;
      doe_q   <= 1'b1;
      dval_q  <= 1'b0;
    end else begin
      bprev_q <= bl;
      wprev_q <= (bl && !bprev_q) ? wl_lv : wprev_q;
      hbit_q  <= hbit_d;
      chan_q  <= chan_d;
      half_q  <= half_d;
      sh_q    <= sh_d;
      rxl_q   <= rxl_d;
      rxr_q   <= rxr_d;
      rxv_q   <= rxv_d;
      txl_q   <= txl_d;
      txr_q   <= txr_d;
      dout_q  <= dout_d;
      doe_q   <= doe_d;
      dval_q  <= dval_d;
    end
  end

  // ==========================================
  // converter re-sync, one machine per converter
  rs_state_t  rs_q [2];
  logic [1:0] drift, pulse_q, mute_q;

  for (genvar i = 0; i < 2; i++) begin : g_rs
    rs_state_t   st_d;
    logic [15:0] cnt_q, cnt_d, mag;
    logic        pulse_d, mute_d;

    always_comb begin
      mag      = delay_err[i][15] ? 16'(-delay_err[i]) : delay_err[i];
      drift[i] = {mag, 2'h0} > {2'h0, period[i]};
      st_d     = rs_q[i];
      cnt_d    = cnt_q + 16'h1;
      case (rs_q[i])
        RS_IDLE: begin
          cnt_d = 16'h0;
          if (fmt_q.rs_en[i] && drift[i])
            st_d = fmt_q.mute_sel ? RS_DOWN : RS_ALIGN;
        end
        RS_DOWN:  if (cnt_q == 16'(MUTE_CYCLES - 1)) st_d = RS_ALIGN;
        RS_ALIGN: begin
          cnt_d = 16'h0;
          st_d  = mute_q[i] ? RS_UP : RS_HOLD;
        end
        RS_UP:    if (cnt_q == 16'(MUTE_CYCLES - 1)) st_d = RS_HOLD;
        RS_HOLD:  if (!drift[i]) st_d = RS_IDLE;
        default:  st_d = RS_IDLE;
      endcase
      // hold waits for the drift to clear so one event aligns once
      pulse_d = st_d == RS_ALIGN;
      mute_d  = st_d == RS_DOWN || st_d == RS_UP || (st_d == RS_ALIGN && mute_q[i]);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        rs_q[i]    <= RS_IDLE;
        cnt_q      <= 16'h0;
        pulse_q[i] <= 1'b0;
        mute_q[i]  <= 1'b0;
      end else begin
        rs_q[i]    <= st_d;
        cnt_q      <= cnt_d;
        pulse_q[i] <= pulse_d;
        mute_q[i]  <= mute_d;
      end
    end
  end

  // ==========================================
  // outputs
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq             = irq_q;
  assign bclk_o          = bclk_q;
  assign bclk_oe         = dir_q[DIR_BCLK_BIT];
  assign wclk_o          = wclk_q;
  assign wclk_oe         = dir_q[DIR_WCLK_BIT];
  assign dout_o          = dout_q;
  assign dout_oe         = doe_q;
  assign rx_left         = rxl_q;
  assign rx_right        = rxr_q;
  assign rx_valid        = rxv_q;
  assign resync_pulse    = pulse_q;
  assign soft_mute       = mute_q;
  assign pll_r_divide    = pdiv_q;

  // ==========================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!srst_b);

  property p_r4;
    (mtick && bclk_q && fmt_q.rate256 && mbit_q == 9'hff) |=> mbit_q == 9'h0;
  endproperty
  a_r4: assert property (p_r4) else $error("256-clock frame did not wrap");

  property p_r5;
    (rs_q[1] == RS_IDLE && fmt_q.rs_en[1] && drift[1] && !fmt_q.mute_sel)
      |=> pulse_q[1] && !mute_q[1];
  endproperty
  a_r5: assert property (p_r5) else $error("playback realign missing");

  property p_r6;
    (rs_q[0] == RS_IDLE && fmt_q.rs_en[0] && drift[0]) |-> ##[1:RS_BOUND] pulse_q[0];
  endproperty
  a_r6: assert property (p_r6) else $error("record realign missing");

  property p_r7;
    (rs_q[1] == RS_IDLE && fmt_q.rs_en[1] && drift[1] && fmt_q.mute_sel)
      |=> mute_q[1] && !pulse_q[1];
  endproperty
  a_r7: assert property (p_r7) else $error("realign not muted first");

  property p_r12;
    ovf_evt[3] |=> ovf_q[3] ##1 (ovf_q[3] || $past(acc_rd));
  endproperty
  a_r12: assert property (p_r12) else $error("overflow flag not sticky");

  property p_r13;
    (acc_rd && avs_address == OFS_OVF && rdata_q[7] && !ovf_evt[3]) |=> !ovf_q[3];
  endproperty
  a_r13: assert property (p_r13) else $error("flag not cleared by read");

  property p_r14;
    ##1 pll_r_divide == (($past(pllr_q) == 4'h0) ? 5'h10 : {1'b0, $past(pllr_q)});
  endproperty
  a_r14: assert property (p_r14) else $error("pll r divide wrong");

  property p_r16;
    (!dir_q[DIR_TRI_BIT] && !$past(acc_wr)) |=> dout_oe;
  endproperty
  a_r16: assert property (p_r16) else $error("data output released");

  property p_r17;
    (ovf_evt[0] && acc_rd && avs_address == OFS_OVF) |=> ovf_q[0];
  endproperty
  a_r17: assert property (p_r17) else $error("overflow lost on read");

  c_frame256: cover property (mtick && bclk_q && fmt_q.rate256 && mbit_q == 9'hff);
  c_mute_rs:  cover property (pulse_q[1] && mute_q[1]);
  c_rd_clear: cover property (acc_rd && avs_address == OFS_OVF && rdata_q[7]);
  c_rx_word:  cover property (rx_valid);

endmodule : codec_serial_port

// ---- codec_host_model.sv ----
// Purpose: host end of the link, left-justified frames with the port as clock slave
// Assumes: bit clock period 160 ns, 32 bit clocks in each half frame
// Notes:   bit clock stands still between frames
`timescale 1ns/1ps
module codec_host_model #(
  parameter int WL = 16
) (
  // control
  input  wire logic        start,
  input  wire logic [7:0]  offset,
  input  wire logic [31:0] left,
  input  wire logic [31:0] right,
  output logic             done,
  output logic [31:0]      cap,
  // link
  output logic             bclk,
  output logic             wclk,
  output logic             din,
  input  wire logic        dout
);
  // ==========================================
  // frame generator
  logic [31:0] w;
  logic        win;
  initial begin
    {bclk, wclk, din, done, cap} = '0;
    forever begin
      @(posedge start);
      done = 1'b0;
      cap = '0;
      for (int h = 0; h < 2; h++) begin
        w = h ? right : left;
        wclk = !h;
        for (int p = 0; p < 32; p++) begin
          win = p >= offset && p < offset + WL;
          // outside the window the line flips, so no stale bit can pass for data
          din = win ? w[WL - 1 - p + offset] : ~din;
          #80 bclk = 1'b1;
          if (win && h == 0)
            cap = {cap[30:0], dout};
          #80 bclk = 1'b0;
        end
      end
      #400 done = 1'b1;
    end
  end
endmodule : codec_host_model

// ---- codec_serial_format_and_overflow_tb_top.sv ----
// Purpose: self-checking bench of the codec serial port block
// Assumes: shortened bit clock and mute counts to keep the run short
// Notes:   link traffic runs with the port as clock slave
`timescale 1ns/1ps
module codec_serial_format_and_overflow_tb_top
  import codec_serial_pkg::*;
();
  logic             core_clk = 1'b0;
  logic             rst_b;
  logic [3:0]       avs_address, avs_byteenable, ovf_evt;
  logic             avs_read, avs_write, avs_waitrequest, irq, rx_valid;
  logic [31:0]      avs_writedata, avs_readdata, tx_left, tx_right, rx_left, rx_right;
  logic             bclk_i, bclk_o, bclk_oe, wclk_i, wclk_o, wclk_oe;
  logic             din_i, dout_o, dout_oe, dout_w;
  logic [1:0][15:0] delay_err, period;
  logic [1:0]       resync_pulse, soft_mute;
  logic [4:0]       pll_r_divide;
  logic             h_start, h_done, h_bclk, h_wclk;
  logic [31:0]      h_left, h_right, h_cap;
  int               err_count = 0;
  int               check_count = 0;

  always #5 core_clk = ~core_clk;

  codec_serial_port #(.BCLK_HALF(1), .MUTE_CYCLES(4)) dut (.core_clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .irq, .bclk_i, .bclk_o, .bclk_oe, .wclk_i, .wclk_o, .wclk_oe, .din_i, .dout_o, .dout_oe,
    .tx_left, .tx_right, .rx_left, .rx_right, .rx_valid, .ovf_evt, .delay_err, .period,
    .resync_pulse, .soft_mute, .pll_r_divide);

  codec_host_model host (.start(h_start), .offset(8'h01), .left(h_left), .right(h_right),
    .done(h_done), .cap(h_cap), .bclk(h_bclk), .wclk(h_wclk), .din(din_i), .dout(dout_w));

  assign bclk_i = bclk_oe ? bclk_o : h_bclk;
  assign wclk_i = wclk_oe ? wclk_o : h_wclk;
  // pulled up while the port releases its data pin
  assign dout_w = dout_oe ? dout_o : 1'b1;

  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // ev is raised in the answer cycle, the very cycle in which a read clears flags
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] ev, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge core_clk);
      ovf_evt <= (n == 0) ? ev : 4'h0;
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      err_count++;
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 4'h0, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [3:0] ev = 4'h0);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, ev, q);
    chk(q, e);
  endtask : rd

  task automatic pulse(input logic [3:0] ev);
    @(posedge core_clk);
    ovf_evt <= ev;
    @(posedge core_clk);
    ovf_evt <= 4'h0;
    tick(3);
  endtask : pulse

  // ==========================================
  // scenarios
  task automatic reset_values();
    chk({dout_oe, pll_r_divide, irq, avs_waitrequest}, {1'b1, 5'h01, 1'b0, 1'b1});
    rd(OFS_FMT, 8'h00);
    rd(OFS_OFFSET, 8'h00);
    rd(OFS_OVF, 8'h01);
    rd(OFS_DIR, 8'h00);
    wr(4'h3, 8'h5a);
    rd(4'h3, 8'h00);
    wr(OFS_OFFSET, 8'hff);
    rd(OFS_OFFSET, 8'hff);
  endtask : reset_values

  task automatic pll_sweep();
    for (int c = 0; c < 16; c++) begin
      wr(OFS_OVF, 8'(c));
      tick(2);
      chk(pll_r_divide, (c == 0) ? 32'h10 : 32'(c));
      rd(OFS_OVF, 8'(c));
    end
    wr(OFS_OVF, 8'h01);
  endtask : pll_sweep

  task automatic overflow();
    wr(OFS_IRQ_MASK, 8'h0f);
    pulse(4'ha);
    chk(irq, 1'b1);
    tick(5);
    rd(OFS_OVF, 8'ha1);
    rd(OFS_OVF, 8'h01);
    rd(OFS_IRQ_ST, 8'h0a);
    wr(OFS_IRQ_ST, 8'h0a);
    tick(3);
    chk(irq, 1'b0);
    wr(OFS_IRQ_MASK, 8'h00);
    pulse(4'h1);
    chk(irq, 1'b0);
    rd(OFS_OVF, 8'h11, 4'h1);
    rd(OFS_OVF, 8'h11);
    rd(OFS_OVF, 8'h01);
    wr(OFS_IRQ_ST, 8'h0f);
  endtask : overflow

  // counts bit clocks of the second whole frame after the format change
  task automatic master_frame(input logic [7:0] fmt, input int bits);
    int f, c, cnt;
    logic pb, pw;
    wr(OFS_DIR, 8'hc0);
    wr(OFS_FMT, fmt);
    chk({bclk_oe, wclk_oe}, 2'b11);
    f = 0;
    c = 0;
    cnt = 0;
    pb = bclk_o;
    pw = wclk_o;
    while (f < 3 && c < 4000) begin
      @(posedge core_clk);
      c++;
      if (pw && !wclk_o)
        f++;
      if (f == 2 && !pb && bclk_o)
        cnt++;
      pb = bclk_o;
      pw = wclk_o;
    end
    chk(cnt, bits);
  endtask : master_frame

  task automatic link_frame();
    int c;
    logic seen;
    wr(OFS_DIR, 8'h00);
    tick(2);
    chk({bclk_oe, wclk_oe}, 2'b00);
    wr(OFS_FMT, 8'hc0);
    wr(OFS_OFFSET, 8'h01);
    tx_left <= 32'h0000a5c3;
    tx_right <= 32'h00005a3c;
    h_left <= 32'h9e17;
    h_right <= 32'h3c81;
    @(posedge core_clk);
    h_start <= 1'b1;
    c = 0;
    seen = 1'b0;
    while (h_done !== 1'b1 && c < 20000) begin
      @(posedge core_clk);
      c++;
      if (rx_valid === 1'b1)
        seen = 1'b1;
    end
    h_start <= 1'b0;
    chk(seen, 1'b1);
    chk(rx_left, 32'h9e17);
    chk(rx_right, 32'h3c81);
    chk(h_cap, 32'ha5c3);
    chk(dout_oe, 1'b1);
    wr(OFS_DIR, 8'h20);
    tick(4);
    chk(dout_oe, 1'b0);
  endtask : link_frame

  // exp bit 0: realign pulse seen, bit 1: soft mute seen
  task automatic resync(input int i, input logic [7:0] fmt, input logic [15:0] e,
                        input logic [1:0] exp);
    logic [1:0] s;
    s = 2'b00;
    wr(OFS_FMT, fmt);
    delay_err[i] <= e;
    for (int c = 0; c < 60; c++) begin
      @(posedge core_clk);
      if (resync_pulse[i] === 1'b1)
        s[0] = 1'b1;
      if (soft_mute[i] === 1'b1)
        s[1] = 1'b1;
    end
    chk(s, exp);
    delay_err[i] <= 16'h0;
    tick(20);
  endtask : resync

  // ==========================================
  // verdict and main sequence
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #300000;
    err_count++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    {ovf_evt, tx_left, tx_right, delay_err} = '0;
    period = {16'h0100, 16'h0100};
    {h_start, h_left, h_right} = '0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    tick(3);
    reset_values();
    pll_sweep();
    overflow();
    master_frame(8'h08, 256);
    master_frame(8'h00, 32);
    master_frame(8'h20, 48);
    master_frame(8'h30, 64);
    master_frame(8'h48, 256);
    master_frame(8'h88, 256);
    link_frame();
    resync(1, 8'h04, 16'h0041, 2'b01);
    resync(1, 8'h04, 16'h0040, 2'b00);
    resync(1, 8'h05, 16'h0041, 2'b11);
    resync(0, 8'h03, 16'hffbf, 2'b11);
    resync(0, 8'h00, 16'h0041, 2'b00);
    print_verdict();
  end
endmodule : codec_serial_format_and_overflow_tb_top
